// >>> include/dfd_pkg.sv
package dfd_pkg;
	// clock and timing
	localparam int CLK_HZ        = 25_000_000;
	localparam int PTC_DELAY_S   = 2;
	localparam int PTC_DELAY_CYC = PTC_DELAY_S * CLK_HZ;
	// structure
	localparam int N_IN = 6;
	localparam int SELW = 6;
	localparam int FW   = 16;
	localparam int SPW  = 20;
	// register byte offsets
	localparam logic [5:0] OFS_SEL_A   = 6'h00;
	localparam logic [5:0] OFS_SEL_B   = 6'h04;
	localparam logic [5:0] OFS_CTRL    = 6'h08;
	localparam logic [5:0] OFS_PRE_12  = 6'h0c;
	localparam logic [5:0] OFS_PRE_34  = 6'h10;
	localparam logic [5:0] OFS_PRE_5J  = 6'h14;
	localparam logic [5:0] OFS_WDOG    = 6'h18;
	localparam logic [5:0] OFS_ESTOP   = 6'h1c;
	localparam logic [5:0] OFS_STATUS  = 6'h20;
	// control field positions
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_BUS  = 1;
	localparam int CTRL_POSI = 2;
	// reset values
	localparam logic [N_IN-1:0][SELW-1:0] SEL_RST = {6'h00, 6'h00, 6'h04, 6'h08, 6'h02, 6'h01};
	localparam logic [31:0] WDOG_RST  = 32'h017d7840;
	localparam logic [15:0] ESTOP_RST = 16'h0000;
	localparam logic [15:0] PRE_RST   = 16'h0000;
	// function codes
	localparam int FN_RIGHT = 1;
	localparam int FN_LEFT  = 2;
	localparam int FN_REV   = 3;
	localparam int FN_PRE1  = 4;
	localparam int FN_PRE4  = 7;
	localparam int FN_PS0   = 8;
	localparam int FN_HOLD  = 9;
	localparam int FN_COAST = 10;
	localparam int FN_QSTOP = 11;
	localparam int FN_ACK   = 12;
	localparam int FN_PTC   = 13;
	localparam int FN_REMOT = 14;
	localparam int FN_JOG   = 15;
	localparam int FN_MPOT  = 16;
	localparam int FN_PS1   = 17;
	localparam int FN_WDOG  = 18;
	localparam int FN_AI1   = 19;
	localparam int FN_AI2   = 20;
	localparam int FN_PRE5  = 21;
	localparam int FN_POS0  = 22;
	localparam int FN_POS3  = 25;
	// bus slave states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK  = 2'b10
	} dfd_bus_e;
endpackage

// >>> hw/dfd_decoder.sv
// Notes on behaviour
// - code 1, edge mode: rising edge enables output, right rotation.
// - code 2, edge mode: rising edge enables output, left rotation.
// - automatic start-up: high level on enable input suffices.
// - right and left enable both high blocks the output.
// - code 3 high reverses the selected rotation direction.
// - codes 4-7 and 21 high add their preset frequency to setpoint.
// - active presets sum with sign, plus analog setpoint with minimum; the code adds analog_setpoint with no minimum applied.
// - codes 8 and 17 give parameter-set bits 0 and 1, high sets.
// - code 9 low holds output frequency during ramps.
// - code 10 low cuts output voltage, motor coasts.
// - code 11 low ramps down with emergency stop time.
// - rising edge on code 12 acknowledges pending fault.
// - without code 12 assigned, falling enable acknowledges fault.
// - code 13 thermistor trip raises fault after two seconds.
// - under bus control, code 14 low hands control to terminals.
// - code 15 high selects stored jog frequency.
// - code 16 holds like code 9 but without min/max clamping.
// - code 18 needs edges within watchdog period, else fault.
// - watchdog supervision starts at first rising edge.
// - codes 19 and 20 switch analog setpoints 1 and 2.
// - codes 22-25 act only with positioning unit fitted.
// - default codes 1,2,8,4,0,0 on inputs 1 to 6.
//
// The Avalon-MM register port and the register addresses were decided locally.
`timescale 1ns/1ps
module dfd_decoder
	import dfd_pkg::*;
#(
	parameter int PTC_DELAY_CYCLES = PTC_DELAY_CYC
)(
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic [5:0]            avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	input  wire logic [N_IN-1:0]       din,
	input  wire logic [FW-1:0]         analog_setpoint,
	output logic                       out_enable,
	output logic                       dir_left,
	output logic                       out_blocked,
	output logic [SPW-1:0]             setpoint,
	output logic [1:0]                 param_set,
	output logic                       ramp_hold,
	output logic                       motor_pot_hold,
	output logic                       coast_stop,
	output logic                       quick_stop,
	output logic [15:0]                emergency_stop_time,
	output logic                       fault_ack,
	output logic                       thermistor_fault,
	output logic                       watchdog_fault,
	output logic                       local_control,
	output logic                       jog_select,
	output logic                       analog1_on,
	output logic                       analog2_on,
	output logic [3:0]                 posi_cmd
);

	typedef struct packed {
		dfd_bus_e                  st;
		logic                      waitreq;
		logic [31:0]               rdata;
		logic [N_IN-1:0][SELW-1:0] sel;
		logic                      auto_st;
		logic                      bus_ctl;
		logic                      posi;
		logic [4:0][FW-1:0]        pre;
		logic [FW-1:0]             jog;
		logic [31:0]               wd_per;
		logic [15:0]               estop;
		logic [N_IN-1:0]           s1;
		logic [N_IN-1:0]           s2;
		logic [N_IN-1:0]           s3;
		logic                      run_r;
		logic                      run_l;
		logic                      wd_arm;
		logic [31:0]               wd_cnt;
		logic [31:0]               ptc_cnt;
		logic                      ptc_flt;
		logic                      wd_flt;
		logic                      en_out;
		logic                      dir_l;
		logic                      blocked;
		logic [SPW-1:0]            sp;
		logic [1:0]                pset;
		logic                      hold;
		logic                      mpot;
		logic                      coast;
		logic                      qstop;
		logic                      ack;
		logic                      local_c;
		logic                      jog_sel;
		logic                      ai1;
		logic                      ai2;
		logic [3:0]                posi_c;
	} dfd_state_s;

	dfd_state_s  r_q;
	dfd_state_s  r_d;
	logic [63:0] hi_v [N_IN];
	logic [63:0] rs_v [N_IN];
	logic [63:0] as_v [N_IN];
	logic [63:0] act_hi;
	logic [63:0] rise;
	logic [63:0] asg;

	// per-input one-hot of its function code, gated by level and edge
	genvar gi;
	for (gi = 0; gi < N_IN; gi++)
	begin : g_in
		logic [63:0] oh;
		assign oh         = 64'h1 << r_q.sel[gi];
		assign as_v[gi]   = oh & ~64'h1;
		assign hi_v[gi]   = as_v[gi] & {64{r_q.s2[gi]}};
		assign rs_v[gi]   = as_v[gi] & {64{r_q.s2[gi] & ~r_q.s3[gi]}};
	end

	// fold inputs into one vector per code; several inputs may share a code
	always_comb
	begin
		act_hi = 64'h0;
		rise   = 64'h0;
		asg    = 64'h0;
		for (int i = 0; i < N_IN; i++)
		begin
			act_hi = act_hi | hi_v[i];
			rise   = rise | rs_v[i];
			asg    = asg | as_v[i];
		end
	end

	function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				m[8*b+:8] = wd[8*b+:8];
		return m;
	endfunction

	// next-state logic for the whole block
	always_comb
	begin
		logic [31:0]    rd;
		logic [31:0]    w;
		logic [SPW-1:0] sp;
		logic [4:0]     pact;
		logic           both;
		logic           en;
		logic           ack;
		r_d  = r_q;
		rd   = 32'h0;
		w    = 32'h0;
		sp   = '0;
		pact = 5'h0;
		both = act_hi[FN_RIGHT] & act_hi[FN_LEFT];
		en   = 1'b0;
		ack  = 1'b0;
		// two-stage sync, third stage only for edge detect
		r_d.s1 = din;
		r_d.s2 = r_q.s1;
		r_d.s3 = r_q.s2;
		// read mux
		case (avs_address & 6'h3c)
			OFS_SEL_A:  rd = {2'h0, r_q.sel[3], 2'h0, r_q.sel[2], 2'h0, r_q.sel[1], 2'h0, r_q.sel[0]};
			OFS_SEL_B:  rd = {16'h0, 2'h0, r_q.sel[5], 2'h0, r_q.sel[4]};
			OFS_CTRL:   rd = {29'h0, r_q.posi, r_q.bus_ctl, r_q.auto_st};
			OFS_PRE_12: rd = {r_q.pre[1], r_q.pre[0]};
			OFS_PRE_34: rd = {r_q.pre[3], r_q.pre[2]};
			OFS_PRE_5J: rd = {r_q.jog, r_q.pre[4]};
			OFS_WDOG:   rd = r_q.wd_per;
			OFS_ESTOP:  rd = {16'h0, r_q.estop};
			OFS_STATUS: rd = {19'h0, r_q.blocked, r_q.en_out, r_q.wd_arm, r_q.wd_flt, r_q.ptc_flt, 2'h0, r_q.s2};
			default:    rd = 32'h0;
		endcase

		// bus slave: answer one cycle after the request, commit the write at the edge that ends the answer cycle
		case (r_q.st)
			BUS_IDLE:
			begin
				if (avs_read || avs_write)
				begin
					r_d.st      = BUS_ACK;
					r_d.waitreq = 1'b0;
					r_d.rdata   = rd;
				end
			end
			BUS_ACK:
			begin
				r_d.st      = BUS_IDLE;
				r_d.waitreq = 1'b1;
				if (avs_write)
				begin
					w = be_merge(rd, avs_writedata, avs_byteenable);
					case (avs_address & 6'h3c)
						OFS_SEL_A:
							for (int i = 0; i < 4; i++)
								r_d.sel[i] = w[8*i+:SELW];
						OFS_SEL_B:
							for (int i = 0; i < 2; i++)
								r_d.sel[4+i] = w[8*i+:SELW];
						OFS_CTRL:
						begin
							r_d.auto_st = w[CTRL_AUTO];
							r_d.bus_ctl = w[CTRL_BUS];
							r_d.posi    = w[CTRL_POSI];
						end
						OFS_PRE_12: r_d.pre[1:0] = w;
						OFS_PRE_34: r_d.pre[3:2] = w;
						OFS_PRE_5J: {r_d.jog, r_d.pre[4]} = w;
						OFS_WDOG:   r_d.wd_per = w;
						OFS_ESTOP:  r_d.estop = w[15:0];
						default:    r_d.rdata = r_q.rdata; // read-only or unmapped: ignored
					endcase
				end
			end
			default:
			begin
				r_d.st      = BUS_IDLE;
				r_d.waitreq = 1'b1;
			end
		endcase

		// direction enables: edge-started latch unless automatic start-up
		if (r_q.auto_st)
		begin
			r_d.run_r = act_hi[FN_RIGHT];
			r_d.run_l = act_hi[FN_LEFT];
		end
		else
		begin
			r_d.run_r = (r_q.run_r | rise[FN_RIGHT]) & act_hi[FN_RIGHT];
			r_d.run_l = (r_q.run_l | rise[FN_LEFT]) & act_hi[FN_LEFT];
		end
		en          = (r_d.run_r | r_d.run_l) & ~both;
		r_d.en_out  = en;
		r_d.blocked = both;
		r_d.dir_l   = (r_d.run_l & ~r_d.run_r) ^ act_hi[FN_REV];

		// fault acknowledge, one-cycle pulse
		ack     = rise[FN_ACK] | (~asg[FN_ACK] & r_q.en_out & ~en);
		r_d.ack = ack;

		// setpoint: signed sum of analog and active presets, jog overrides
		pact = {act_hi[FN_PRE5], act_hi[FN_PRE4:FN_PRE1]};
		sp   = {{(SPW-FW){analog_setpoint[FW-1]}}, analog_setpoint};
		for (int k = 0; k < 5; k++)
			if (pact[k])
				sp = sp + {{(SPW-FW){r_q.pre[k][FW-1]}}, r_q.pre[k]};
		if (act_hi[FN_JOG])
			sp = {{(SPW-FW){r_q.jog[FW-1]}}, r_q.jog};
		r_d.sp      = sp;
		r_d.jog_sel = act_hi[FN_JOG];

		// level functions; active-low ones only count when assigned
		r_d.pset    = {act_hi[FN_PS1], act_hi[FN_PS0]};
		r_d.hold    = asg[FN_HOLD] & ~act_hi[FN_HOLD];
		r_d.mpot    = asg[FN_MPOT] & ~act_hi[FN_MPOT];
		r_d.coast   = asg[FN_COAST] & ~act_hi[FN_COAST];
		r_d.qstop   = asg[FN_QSTOP] & ~act_hi[FN_QSTOP];
		r_d.local_c = r_q.bus_ctl & asg[FN_REMOT] & ~act_hi[FN_REMOT];
		r_d.ai1     = act_hi[FN_AI1];
		r_d.ai2     = act_hi[FN_AI2];
		r_d.posi_c  = r_q.posi ? act_hi[FN_POS3:FN_POS0] : 4'h0;

		// input watchdog: ack clears first so a fresh timeout still wins
		if (ack)
			r_d.wd_flt = 1'b0;
		if (!asg[FN_WDOG])
			r_d.wd_arm = 1'b0;
		else if (rise[FN_WDOG])
		begin
			r_d.wd_arm = 1'b1;
			r_d.wd_cnt = 32'h0;
		end
		else if (r_q.wd_arm)
		begin
			if (r_q.wd_cnt >= r_q.wd_per - 32'h1)
			begin
				r_d.wd_flt = 1'b1;
				r_d.wd_arm = 1'b0; // rearm only on the next edge
			end
			else
				r_d.wd_cnt = r_q.wd_cnt + 32'h1;
		end

		// thermistor: trip level must persist for the whole delay
		if (ack && !act_hi[FN_PTC])
			r_d.ptc_flt = 1'b0;
		if (act_hi[FN_PTC])
		begin
			if (r_q.ptc_cnt >= 32'(PTC_DELAY_CYCLES - 1))
				r_d.ptc_flt = 1'b1;
			else
				r_d.ptc_cnt = r_q.ptc_cnt + 32'h1;
		end
		else
			r_d.ptc_cnt = 32'h0;
	end

	// state register with defined reset
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			r_q         <= '0;
			r_q.st      <= BUS_IDLE;
			r_q.waitreq <= 1'b1;
			r_q.sel     <= SEL_RST;
			r_q.pre     <= {5{PRE_RST}};
			r_q.jog     <= PRE_RST;
			r_q.wd_per  <= WDOG_RST;
			r_q.estop   <= ESTOP_RST;
		end
		else
			r_q <= r_d;
	end

	assign avs_readdata        = r_q.rdata;
	assign avs_waitrequest     = r_q.waitreq;
	assign out_enable          = r_q.en_out;
	assign dir_left            = r_q.dir_l;
	assign out_blocked         = r_q.blocked;
	assign setpoint            = r_q.sp;
	assign param_set           = r_q.pset;
	assign ramp_hold           = r_q.hold;
	assign motor_pot_hold      = r_q.mpot;
	assign coast_stop          = r_q.coast;
	assign quick_stop          = r_q.qstop;
	assign emergency_stop_time = r_q.estop;
	assign fault_ack           = r_q.ack;
	assign thermistor_fault    = r_q.ptc_flt;
	assign watchdog_fault      = r_q.wd_flt;
	assign local_control       = r_q.local_c;
	assign jog_select          = r_q.jog_sel;
	assign analog1_on          = r_q.ai1;
	assign analog2_on          = r_q.ai2;
	assign posi_cmd            = r_q.posi_c;

	// checks on decoded behaviour
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_edge_right;
		!r_q.auto_st && rise[FN_RIGHT] && !act_hi[FN_LEFT] && !act_hi[FN_REV] |=> r_q.en_out && !r_q.dir_l;
	endproperty
	a_edge_right: assert property (p_edge_right) else $error("right edge did not enable");

	property p_edge_left;
		!r_q.auto_st && rise[FN_LEFT] && !act_hi[FN_RIGHT] && !act_hi[FN_REV] |=> r_q.en_out && r_q.dir_l;
	endproperty
	a_edge_left: assert property (p_edge_left) else $error("left edge did not enable");

	property p_level_auto;
		r_q.auto_st && act_hi[FN_RIGHT] && !act_hi[FN_LEFT] |=> r_q.en_out;
	endproperty
	a_level_auto: assert property (p_level_auto) else $error("level start failed");

	property p_block;
		act_hi[FN_RIGHT] && act_hi[FN_LEFT] |=> !r_q.en_out && r_q.blocked;
	endproperty
	a_block: assert property (p_block) else $error("both enables not blocked");

	property p_reverse;
		act_hi[FN_RIGHT] && !act_hi[FN_LEFT] && act_hi[FN_REV] |=> r_q.dir_l;
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse ignored");

	property p_plain_sp;
		!act_hi[FN_JOG] && ({act_hi[FN_PRE5], act_hi[FN_PRE4:FN_PRE1]} == 5'h0)
			|=> $signed(r_q.sp) == $signed($past(analog_setpoint));
	endproperty
	a_plain_sp: assert property (p_plain_sp) else $error("setpoint not analog alone");

	property p_coast;
		asg[FN_COAST] && !act_hi[FN_COAST]
			|=> r_q.coast ##1 (r_q.coast || $past(act_hi[FN_COAST]) || !$past(asg[FN_COAST]));
	endproperty
	a_coast: assert property (p_coast) else $error("coast stop missing");

	property p_ack;
		rise[FN_ACK] |=> r_q.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("fault ack missing");

	property p_ptc_delay;
		$rose(r_q.ptc_flt) |-> $past(r_q.ptc_cnt) == 32'(PTC_DELAY_CYCLES - 1);
	endproperty
	a_ptc_delay: assert property (p_ptc_delay) else $error("thermistor delay wrong");

	property p_wd_armed;
		$rose(r_q.wd_flt) |-> $past(r_q.wd_arm);
	endproperty
	a_wd_armed: assert property (p_wd_armed) else $error("watchdog fault before arming");

	property p_posi;
		!r_q.posi |=> r_q.posi_c == 4'h0;
	endproperty
	a_posi: assert property (p_posi) else $error("positioning active without unit");

	property p_bus;
		r_q.st == BUS_IDLE && (avs_read || avs_write) |=> !r_q.waitreq ##1 r_q.waitreq;
	endproperty
	a_bus: assert property (p_bus) else $error("bus answer timing wrong");

	c_block: cover property (act_hi[FN_RIGHT] && act_hi[FN_LEFT]);
	c_wd_flt: cover property ($rose(r_q.wd_flt));
	c_ptc_flt: cover property ($rose(r_q.ptc_flt));
	c_write: cover property (r_q.st == BUS_ACK && avs_write);

endmodule // dfd_decoder

// >>> sim/dfd_switches.sv
`timescale 1ns/1ps
module dfd_switches
	import dfd_pkg::*;
(
	input  wire logic            sys_clk,
	input  wire logic [N_IN-1:0] level,
	input  wire logic            pulse_on,
	input  wire logic [7:0]      pulse_per,
	input  wire logic [2:0]      pulse_idx,
	output logic      [N_IN-1:0] din
);
	logic [7:0] cnt;
	logic       tick;

	// heartbeat source for the watchdog line, one-cycle high pulse per period
	always_ff @(posedge sys_clk)
	begin
		if (!pulse_on || cnt >= pulse_per - 8'h01)
			cnt <= 8'h00;
		else
			cnt <= cnt + 8'h01;
		tick <= pulse_on && cnt == 8'h00;
	end

	// switch contacts: plain levels, heartbeat merged on the chosen line
	always_comb
		din = level | (N_IN'(tick) << pulse_idx);
endmodule // dfd_switches

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench
	import dfd_pkg::*;
;
	logic            sys_clk = 1'b0;
	logic            rst = 1'b1;
	logic [5:0]      avs_address = 6'h00;
	logic            avs_read = 1'b0;
	logic            avs_write = 1'b0;
	logic [31:0]     avs_writedata = 32'h0;
	logic [3:0]      avs_byteenable = 4'hf;
	logic [31:0]     avs_readdata;
	logic            avs_waitrequest;
	logic [N_IN-1:0] din, lvl = 6'h00;
	logic [FW-1:0]   analog_setpoint = 16'h0100;
	logic            out_enable, dir_left, out_blocked, ramp_hold, motor_pot_hold, coast_stop, quick_stop;
	logic            fault_ack, thermistor_fault, watchdog_fault, local_control, jog_select, analog1_on, analog2_on;
	logic [SPW-1:0]  setpoint;
	logic [1:0]      param_set;
	logic [15:0]     emergency_stop_time;
	logic [3:0]      posi_cmd;
	logic            pulse_on = 1'b0;
	int              errors = 0, total_checks = 0, cyc = 0, ack_cnt = 0;

	always #20 sys_clk = ~sys_clk;

	dfd_decoder #(.PTC_DELAY_CYCLES(20)) dfd_decoder_inst (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .din(din), .analog_setpoint(analog_setpoint),
		.out_enable(out_enable), .dir_left(dir_left), .out_blocked(out_blocked), .setpoint(setpoint),
		.param_set(param_set), .ramp_hold(ramp_hold), .motor_pot_hold(motor_pot_hold), .coast_stop(coast_stop),
		.quick_stop(quick_stop), .emergency_stop_time(emergency_stop_time), .fault_ack(fault_ack),
		.thermistor_fault(thermistor_fault), .watchdog_fault(watchdog_fault), .local_control(local_control),
		.jog_select(jog_select), .analog1_on(analog1_on), .analog2_on(analog2_on), .posi_cmd(posi_cmd));

	dfd_switches dfd_switches_inst (.sys_clk(sys_clk), .level(lvl), .pulse_on(pulse_on), .pulse_per(8'h04),
		.pulse_idx(3'h5), .din(din));

	task print_verdict;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// hang guard, far above the roughly five hundred cycles the run needs
	always @(posedge sys_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			errors++;
			print_verdict();
		end
	end

	// one-cycle acknowledge pulses are counted, so a repeat would show
	always @(posedge sys_clk)
		if (fault_ack === 1'b1)
			ack_cnt <= ack_cnt + 1;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// request held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be,
		output logic [31:0] q);
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= ~wr;
		// no local limit: only the hang guard ends a stuck wait
		do
			@(posedge sys_clk);
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rd(input string nm, input logic [5:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, 4'hf, q);
		check(nm, q, exp);
	endtask

	// input path is two sync stages plus the output flop
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	function automatic logic obs(input int c);
		case (c)
			8: return param_set[0];
			9: return ramp_hold;
			10: return coast_stop;
			11: return quick_stop;
			14: return local_control;
			15: return jog_select;
			16: return motor_pot_hold;
			17: return param_set[1];
			19: return analog1_on;
			20: return analog2_on;
			22, 23, 24, 25: return posi_cmd[c - 22];
			default: return |{param_set, ramp_hold, motor_pot_hold, coast_stop, quick_stop, local_control,
				jog_select, analog1_on, analog2_on, posi_cmd};
		endcase
	endfunction

	function automatic logic [19:0] sx(input logic [15:0] v);
		return {{4{v[15]}}, v};
	endfunction

	initial
	begin
		int codes[15] = '{0, 8, 9, 10, 11, 14, 15, 16, 17, 19, 20, 22, 23, 24, 25};
		int pc[5] = '{4, 5, 6, 7, 21};
		logic [15:0] pv[5] = '{16'h0010, 16'hfff0, 16'h0020, 16'h0040, 16'h0080};
		logic lo;
		logic [31:0] q;
		int a0;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		// register defaults and an unmapped hole
		rd("select a", OFS_SEL_A, 32'h04080201);
		rd("select b", OFS_SEL_B, 32'h0);
		rd("watchdog period", OFS_WDOG, 32'h017d7840);
		rd("unmapped", 6'h3c, 32'h0);
		// byte lanes merge into the stop time
		wr(OFS_ESTOP, 32'h00001234);
		bus(1'b1, OFS_ESTOP, 32'h0000ab99, 4'h1, q);
		rd("stop time reg", OFS_ESTOP, 32'h00001299);
		check("stop time out", {16'h0, emergency_stop_time}, 32'h1299);
		// both enables rising together: blocked, and the right edge still latched afterwards
		lvl <= 6'h03;
		settle(5);
		check("blocked", {31'h0, out_blocked}, 32'h1);
		check("enable when blocked", {31'h0, out_enable}, 32'h0);
		lvl <= 6'h01;
		settle(5);
		// the edge seen while blocked stays latched, so right runs once left drops
		check("enable after block lifts", {31'h0, out_enable}, 32'h1);
		wr(OFS_CTRL, 32'h1);
		settle(5);
		check("enable by level", {31'h0, out_enable}, 32'h1);
		lvl <= 6'h00;
		settle(5);
		wr(OFS_CTRL, 32'h0);
		lvl <= 6'h02;
		settle(5);
		check("left enable", {30'h0, out_enable, dir_left}, 32'h3);
		a0 = ack_cnt;
		lvl <= 6'h00;
		settle(6);
		check("ack by enable fall", 32'(ack_cnt - a0), 32'h1);
		lvl <= 6'h01;
		settle(5);
		check("right enable", {30'h0, out_enable, dir_left}, 32'h2);
		wr(OFS_SEL_A, 32'h04030201);
		lvl <= 6'h05;
		settle(5);
		check("reversed", {31'h0, dir_left}, 32'h1);
		lvl <= 6'h00;
		// each preset alone, then two of them with opposite signs
		wr(OFS_PRE_12, 32'hfff00010);
		wr(OFS_PRE_34, 32'h00400020);
		wr(OFS_PRE_5J, 32'h03000080);
		foreach (pc[i])
		begin
			wr(OFS_SEL_B, 32'(pc[i]) << 8);
			lvl <= 6'h20;
			settle(5);
			check("preset sum", {12'h0, setpoint}, {12'h0, sx(16'h0100) + sx(pv[i])});
		end
		wr(OFS_SEL_B, 32'h00001505);
		lvl <= 6'h30;
		settle(5);
		check("signed sum", {12'h0, setpoint}, {12'h0, sx(16'h0100) + sx(16'hfff0) + sx(16'h0080)});
		// level functions, with bus control and the positioning unit present
		wr(OFS_CTRL, 32'h6);
		foreach (codes[i])
		begin
			wr(OFS_SEL_B, 32'(codes[i]) << 8);
			lo = codes[i] inside {9, 10, 11, 14, 16};
			for (int v = 0; v < 2; v++)
			begin
				lvl <= {v[0], 5'h00};
				settle(5);
				check("level function", {31'h0, obs(codes[i])}, {31'h0, codes[i] != 0 && (v[0] ^ lo)});
				if (codes[i] == 15 && v == 1)
					check("jog setpoint", {12'h0, setpoint}, {12'h0, sx(16'h0300)});
			end
		end
		wr(OFS_CTRL, 32'h2);
		settle(5);
		check("positioning absent", {28'h0, posi_cmd}, 32'h0);
		// acknowledge edge counted once while the level stays high
		lvl <= 6'h00;
		wr(OFS_SEL_B, 32'h00000c00);
		a0 = ack_cnt;
		lvl <= 6'h20;
		settle(10);
		check("ack edge", 32'(ack_cnt - a0), 32'h1);
		// thermistor trip must last the whole delay
		lvl <= 6'h00;
		wr(OFS_SEL_B, 32'h00000d00);
		lvl <= 6'h20;
		settle(10);
		check("thermistor early", {31'h0, thermistor_fault}, 32'h0);
		settle(20);
		check("thermistor late", {31'h0, thermistor_fault}, 32'h1);
		// watchdog idle until armed, quiet while fed, trips when feeding stops
		lvl <= 6'h00;
		wr(OFS_WDOG, 32'd10);
		wr(OFS_SEL_B, 32'h00001200);
		settle(30);
		check("watchdog unarmed", {31'h0, watchdog_fault}, 32'h0);
		pulse_on <= 1'b1;
		settle(40);
		check("watchdog fed", {31'h0, watchdog_fault}, 32'h0);
		pulse_on <= 1'b0;
		settle(20);
		check("watchdog starved", {31'h0, watchdog_fault}, 32'h1);
		print_verdict();
	end
endmodule // testbench
